//--- fbe_resp.sv
// fram bit error response: reset request, nmi, cause vectors, flags
// Rules for this block and for the software that drives it
// R1: uncorrectable error requests power-up-clear reset only when reset enable is set.
// R2: that reset loads the uncorrectable cause code into the reset vector.
// R3: uncorrectable error raises nmi with its code only when its enable set.
// R4: correctable error raises nmi with its code only when its enable set; an uncorrectable nmi in the same cycle puts its own code instead.
// R5: fast main clock makes uncorrectable detections false ones during fram execution.
// R6: such false reset leaves reset vector zero and uncorrectable flag clear.
// R7: after low-power wakeup, detections may be false yet are still acted on.
// R8: software ignores resets whose cause vector reads zero.
// R9: software keeps main clock at 12 MHz or clears reset enable.
// R10: software clears reset and both nmi enables before low-power entry.
// R11: software clears both flags after wakeup, restores config after valid access.
// R12: software makes the first valid access reach the array, not a cache.
// R13: genuine detection sets its flag, which stays until software clears it.
`timescale 1ns/10ps
module fbe_resp #(
	parameter int VEC_W = fbe_pkg::VEC_W
) (
	input  wire logic                     CLK,
	input  wire logic                     RST_B,
	input  wire logic                     FRAM_RD_VALID,
	input  wire logic                     FRAM_UNCORR_ERR,
	input  wire logic                     FRAM_CORR_ERR,
	input  wire logic                     MCLK_FAST,
	input  wire logic                     LPM_WAKEUP,
	input  wire logic                     UNCORR_ERR_RESET_EN,
	input  wire logic                     UNCORR_ERR_NMI_EN,
	input  wire logic                     CORR_ERR_NMI_EN,
	input  wire logic                     UNCORR_FLAG_CLR,
	input  wire logic                     CORR_FLAG_CLR,
	input  wire logic                     RESET_CAUSE_ACK,
	input  wire logic                     NMI_CAUSE_ACK,
	output logic                          POWER_UP_CLEAR_RESET,
	output logic [fbe_pkg::VEC_W-1:0]     RESET_CAUSE_VECTOR,
	output logic                          NMI,
	output logic [fbe_pkg::VEC_W-1:0]     SYSTEM_NMI_VECTOR,
	output logic                          UNCORR_ERR_FLAG,
	output logic                          CORR_ERR_FLAG,
	output logic                          POST_WAKE
);
	import fbe_pkg::*;

	// cause codes are fixed at eight bits, other widths cannot hold them
	if (VEC_W != 8) begin : g_bad_width
		$error("fbe_resp: VEC_W must be 8");
	end

	logic             uncorr_hit;
	logic             corr_hit;
	logic             false_uncorr;
	logic             real_uncorr;
	logic             puc_nxt;
	logic             uncorr_nmi;
	logic             corr_nmi;
	logic             nmi_nxt;
	logic [VEC_W-1:0] rst_vec_nxt;
	logic [VEC_W-1:0] nmi_vec_nxt;
	logic [VEC_W-1:0] rst_code;
	logic [VEC_W-1:0] nmi_code;
	logic [FLAG_N-1:0] flag_set;
	logic [FLAG_N-1:0] flag_clr;
	logic [FLAG_N-1:0] flag_q;
	logic             puc_r;
	logic             nmi_r;
	logic [VEC_W-1:0] rst_vec_r;
	logic [VEC_W-1:0] nmi_vec_r;
	fbe_state_t       state_r;
	fbe_state_t       state_nxt;
	logic             post_wake_nxt;
	logic             post_wake_r;

	// detections count only on a completed array read
	assign uncorr_hit   = FRAM_RD_VALID & FRAM_UNCORR_ERR;
	assign corr_hit     = FRAM_RD_VALID & FRAM_CORR_ERR;
	// with a fast main clock the array sense path trips falsely
	assign false_uncorr = uncorr_hit & MCLK_FAST; // R5
	assign real_uncorr  = uncorr_hit & ~MCLK_FAST;

	// reset request gated by its enable, false or not
	assign puc_nxt  = uncorr_hit & UNCORR_ERR_RESET_EN; // R1
	// a false hit resets with no cause recorded
	assign rst_code = false_uncorr ? RST_CAUSE_NONE   // R6
	                               : RST_CAUSE_UNCORR; // R2
	// vector kept across the reset it describes; ack clears it
	assign rst_vec_nxt = puc_nxt         ? rst_code :
	                     RESET_CAUSE_ACK ? RST_CAUSE_NONE : rst_vec_r;

	// nmi sources; uncorrectable outranks correctable on the vector
	assign uncorr_nmi  = real_uncorr & UNCORR_ERR_NMI_EN; // R3
	assign corr_nmi    = corr_hit & CORR_ERR_NMI_EN; // R4
	assign nmi_nxt     = uncorr_nmi | corr_nmi;
	assign nmi_code    = uncorr_nmi ? NMI_CAUSE_UNCORR : NMI_CAUSE_CORR;
	// a new cause overrides an ack in the same cycle so it is not lost
	assign nmi_vec_nxt = nmi_nxt       ? nmi_code :
	                     NMI_CAUSE_ACK ? NMI_CAUSE_NONE : nmi_vec_r;

	// false hits leave the uncorrectable flag untouched
	assign flag_set[FLAG_UNCORR] = real_uncorr; // R6 R13
	assign flag_set[FLAG_CORR]   = corr_hit; // R13
	assign flag_clr[FLAG_UNCORR] = UNCORR_FLAG_CLR;
	assign flag_clr[FLAG_CORR]   = CORR_FLAG_CLR;

	fbe_flag #(
		.N    (FLAG_N)
	) u_flag (
		.CLK  (CLK),
		.RST_B(RST_B),
		.SET  (flag_set),
		.CLR  (flag_clr),
		.FLAG (flag_q)
	);

	// wake window: open from wakeup until the first completed read;
	// hits inside it are acted on like any other, the array cannot tell
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_RUN: begin
				if (LPM_WAKEUP) begin
					state_nxt = ST_WAKE; // R7
				end
			end
			ST_WAKE: begin
				// a wakeup in the read cycle keeps the window open
				if (!LPM_WAKEUP && FRAM_RD_VALID) begin
					state_nxt = ST_RUN; // R7
				end
			end
		endcase
	end

	// window flag registered so the output comes from a flip-flop
	assign post_wake_nxt = (state_nxt == ST_WAKE);

	// response pulses and cause vectors
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			puc_r     <= PULSE_RST;
			nmi_r     <= PULSE_RST;
			rst_vec_r <= RST_CAUSE_NONE;
			nmi_vec_r <= NMI_CAUSE_NONE;
		end else begin
			puc_r     <= puc_nxt;
			nmi_r     <= nmi_nxt;
			rst_vec_r <= rst_vec_nxt;
			nmi_vec_r <= nmi_vec_nxt;
		end
	end

	// wake window state
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_r     <= ST_RUN;
			post_wake_r <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			post_wake_r <= post_wake_nxt;
		end
	end

	assign POWER_UP_CLEAR_RESET = puc_r;
	assign NMI                  = nmi_r;
	assign RESET_CAUSE_VECTOR   = rst_vec_r;
	assign SYSTEM_NMI_VECTOR    = nmi_vec_r;
	assign UNCORR_ERR_FLAG      = flag_q[FLAG_UNCORR];
	assign CORR_ERR_FLAG        = flag_q[FLAG_CORR];
	assign POST_WAKE            = post_wake_r;

	// checks on the response timing and codes
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	puc_gated_a: assert property ( // R1
		$rose(POWER_UP_CLEAR_RESET) || POWER_UP_CLEAR_RESET |->
		$past(uncorr_hit) && $past(UNCORR_ERR_RESET_EN))
		else $error("reset pulse without enabled uncorrectable hit");

	puc_cause_a: assert property ( // R2
		FRAM_RD_VALID && FRAM_UNCORR_ERR && UNCORR_ERR_RESET_EN &&
		!MCLK_FAST |=> POWER_UP_CLEAR_RESET &&
		RESET_CAUSE_VECTOR == RST_CAUSE_UNCORR)
		else $error("reset cause code missing after real hit");

	uncorr_nmi_a: assert property ( // R3
		FRAM_RD_VALID && FRAM_UNCORR_ERR && !MCLK_FAST &&
		UNCORR_ERR_NMI_EN |=> NMI &&
		SYSTEM_NMI_VECTOR == NMI_CAUSE_UNCORR)
		else $error("uncorrectable nmi or code missing");

	corr_nmi_a: assert property ( // R4
		NMI && SYSTEM_NMI_VECTOR == NMI_CAUSE_CORR |->
		$past(corr_hit) && $past(CORR_ERR_NMI_EN) && !$past(uncorr_nmi))
		else $error("correctable nmi without enabled cause");

	corr_code_a: assert property ( // R4
		corr_hit && CORR_ERR_NMI_EN && !uncorr_nmi |=> NMI &&
		SYSTEM_NMI_VECTOR == NMI_CAUSE_CORR)
		else $error("correctable nmi or code missing");

	rst_vec_hold_a: assert property ( // R2
		!puc_nxt && !RESET_CAUSE_ACK |=> $stable(RESET_CAUSE_VECTOR))
		else $error("reset cause changed without reset or ack");

	nmi_quiet_a: assert property ( // R3 R4
		!UNCORR_ERR_NMI_EN && !CORR_ERR_NMI_EN |=> !NMI)
		else $error("nmi raised with both enables low");

	false_puc_a: assert property ( // R5 R6
		uncorr_hit && MCLK_FAST && UNCORR_ERR_RESET_EN |=>
		POWER_UP_CLEAR_RESET && RESET_CAUSE_VECTOR == RST_CAUSE_NONE &&
		UNCORR_ERR_FLAG == $past(UNCORR_ERR_FLAG && !UNCORR_FLAG_CLR))
		else $error("false reset recorded a cause or set the flag");

	wake_window_a: assert property ( // R7
		LPM_WAKEUP ##1 !FRAM_RD_VALID && !LPM_WAKEUP |->
		POST_WAKE ##1 POST_WAKE)
		else $error("wake window closed without a read");

	flag_sticky_a: assert property ( // R13
		(UNCORR_ERR_FLAG && !UNCORR_FLAG_CLR) [*2] |->
		UNCORR_ERR_FLAG ##1 UNCORR_ERR_FLAG)
		else $error("uncorrectable flag dropped without clear");

	set_wins_a: assert property ( // R13
		corr_hit && CORR_FLAG_CLR |=> CORR_ERR_FLAG)
		else $error("correctable event lost to clear");

	real_hit_c: cover property (
		uncorr_hit && !MCLK_FAST ##1 POWER_UP_CLEAR_RESET && NMI);
	false_hit_c: cover property (
		false_uncorr && UNCORR_ERR_RESET_EN ##1 POWER_UP_CLEAR_RESET);
	wake_err_c: cover property (
		POST_WAKE && corr_hit && CORR_ERR_NMI_EN ##1 NMI);
	clear_c: cover property (CORR_ERR_FLAG ##1 CORR_FLAG_CLR ##1
		!CORR_ERR_FLAG);
endmodule // fbe_resp

//--- fbe_pkg.sv
// constants shared by the fram bit error response logic
package fbe_pkg;
	// width of the cause vectors seen by software
	localparam int          VEC_W            = 8;
	// reset cause codes; zero means no defined source
	localparam logic [7:0]  RST_CAUSE_NONE   = 8'h00;
	localparam logic [7:0]  RST_CAUSE_UNCORR = 8'h1c;
	// system nmi cause codes
	localparam logic [7:0]  NMI_CAUSE_NONE   = 8'h00;
	localparam logic [7:0]  NMI_CAUSE_UNCORR = 8'h02;
	localparam logic [7:0]  NMI_CAUSE_CORR   = 8'h04;
	// sticky flag positions and count
	localparam int          FLAG_N           = 2;
	localparam int          FLAG_UNCORR      = 0;
	localparam int          FLAG_CORR        = 1;
	// reset values
	localparam logic        FLAG_RST         = 1'b0;
	localparam logic        PULSE_RST        = 1'b0;
	// wake window tracker, one-hot
	typedef enum logic [1:0] {
		ST_RUN  = 2'b01,
		ST_WAKE = 2'b10
	} fbe_state_t;
endpackage

//--- fbe_flag.sv
// sticky error flag bank, hardware set wins over software clear
`timescale 1ns/10ps
module fbe_flag #(
	parameter int N = 2
) (
	input  wire logic         CLK,
	input  wire logic         RST_B,
	input  wire logic [N-1:0] SET,
	input  wire logic [N-1:0] CLR,
	output logic      [N-1:0] FLAG
);
	import fbe_pkg::*;

	// an empty bank has nothing to hold
	if (N < 1) begin : g_bad_n
		$error("fbe_flag: N must be at least 1");
	end

	logic [N-1:0] flag_r;
	logic [N-1:0] flag_nxt;

	// set beats clear so an event in the clear cycle is kept
	assign flag_nxt = SET | (flag_r & ~CLR); // R13
	assign FLAG     = flag_r;

	// flags held until software clears them
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			flag_r <= {N{FLAG_RST}};
		end else begin
			flag_r <= flag_nxt;
		end
	end
endmodule // fbe_flag

//--- fbe_fram_model.sv
// fram array read model, driven by the bench acting as cpu software
`timescale 1ns/10ps
module fbe_fram_model (
	input  wire logic CLK,
	input  wire logic RST_B,
	input  wire logic REQ,
	input  wire logic UE,
	input  wire logic CE,
	output logic      RD_VALID,
	output logic      UERR,
	output logic      CERR
);
	// every request is a real array read, never a cache hit; outside a
	// read the error lines toggle so a stale level cannot pass for a hit
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			RD_VALID <= 1'b0;
			UERR     <= 1'b0;
			CERR     <= 1'b0;
		end else begin
			RD_VALID <= REQ;
			UERR     <= REQ ? UE : ~UERR;
			CERR     <= REQ ? CE : ~CERR;
		end
	end
endmodule // fbe_fram_model

//--- fram_bit_error_response_bench.sv
// self-checking bench for the fram bit error response block
`timescale 1ns/10ps
module fram_bit_error_response_bench;
	import fbe_pkg::*;
	logic        clk, rst_b, req, ue, ce, fast, wake, ren, uen, cen;
	logic        uclr, cclr, rack, nack, rdv, uerr, cerr;
	logic        power_up_clear_reset, nmi, uflag, cflag, post_wake;
	logic [7:0]  rvec, nvec;
	logic [25:0] rows [8];
	int          failures, compares;

	fbe_fram_model fram (.CLK(clk), .RST_B(rst_b), .REQ(req), .UE(ue),
		.CE(ce), .RD_VALID(rdv), .UERR(uerr), .CERR(cerr));
	fbe_resp dut (.CLK(clk), .RST_B(rst_b), .FRAM_RD_VALID(rdv),
		.FRAM_UNCORR_ERR(uerr), .FRAM_CORR_ERR(cerr), .MCLK_FAST(fast),
		.LPM_WAKEUP(wake), .UNCORR_ERR_RESET_EN(ren),
		.UNCORR_ERR_NMI_EN(uen), .CORR_ERR_NMI_EN(cen),
		.UNCORR_FLAG_CLR(uclr), .CORR_FLAG_CLR(cclr),
		.RESET_CAUSE_ACK(rack), .NMI_CAUSE_ACK(nack),
		.POWER_UP_CLEAR_RESET(power_up_clear_reset), .RESET_CAUSE_VECTOR(rvec), .NMI(nmi),
		.SYSTEM_NMI_VECTOR(nvec), .UNCORR_ERR_FLAG(uflag),
		.CORR_ERR_FLAG(cflag), .POST_WAKE(post_wake));

	// compare four-state values so an unknown never matches
	task automatic chk(input string what, input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one array read; config {ue,ce,fast,ren,uen,cen}, results settle after
	task automatic rd(input logic [5:0] in);
		@(posedge clk);
		{ue, ce, fast, ren, uen, cen} <= in;
		req <= 1'b1;
		@(posedge clk);
		req <= 1'b0;
		@(posedge clk);
		#1;
	endtask

	// software clears both flags and acknowledges both vectors
	task automatic clr_all();
		@(posedge clk);
		{uclr, cclr, rack, nack} <= 4'hf;
		@(posedge clk);
		{uclr, cclr, rack, nack} <= 4'h0;
		#1;
	endtask

	task automatic test_done();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// 200 mhz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// the whole run needs about 70 cycles; give it about seventeen times that
	initial begin
		#6000;
		failures++;
		test_done();
	end

	initial begin
		rst_b = 1'b0;
		req = 1'b0;
		wake = 1'b0;
		{ue, ce, fast, ren, uen, cen} = 6'h00;
		{uclr, cclr, rack, nack} = 4'h0;
		failures = 0;
		compares = 0;
		// {ue,ce,fast,ren,uen,cen}, {puc, rvec, nmi, nvec, uflag, cflag}
		rows = '{{6'h27, 1'b1, 8'h1c, 1'b1, 8'h02, 2'h2},
			{6'h23, 1'b0, 8'h00, 1'b1, 8'h02, 2'h2},
			{6'h25, 1'b1, 8'h1c, 1'b0, 8'h00, 2'h2},
			{6'h2f, 1'b1, 8'h00, 1'b0, 8'h00, 2'h0},
			{6'h17, 1'b0, 8'h00, 1'b1, 8'h04, 2'h1},
			{6'h16, 1'b0, 8'h00, 1'b0, 8'h00, 2'h1},
			{6'h37, 1'b1, 8'h1c, 1'b1, 8'h02, 2'h3},
			{6'h31, 1'b0, 8'h00, 1'b1, 8'h04, 2'h3}};
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		chk("after reset", {power_up_clear_reset, rvec, nmi, nvec, uflag, cflag, post_wake}, 0);
		// rows[3], the fourth row, runs a fast main clock with reset enabled on purpose
		foreach (rows[i]) begin
			rd(rows[i][25:20]);
			chk("row", {power_up_clear_reset, rvec, nmi, nvec, uflag, cflag}, rows[i][19:0]);
			clr_all();
		end
		// flag must hold through idle cycles and a clear of the other one
		rd(6'h20);
		repeat (3) @(posedge clk);
		cclr <= 1'b1;
		@(posedge clk);
		cclr <= 1'b0;
		#1;
		chk("sticky flags", {uflag, cflag}, 2'h2);
		clr_all();
		// wake window closes on the first read, whose error still acts
		@(posedge clk);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		#1;
		chk("wake window", post_wake, 1'b1);
		rd(6'h37);
		chk("wake read", {post_wake, power_up_clear_reset, rvec}, {1'b0, 1'b1, 8'h1c});
		clr_all();
		chk("cleared", {uflag, cflag, rvec, nvec}, 0);
		// a hit and a clear in one cycle: the hit is kept
		@(posedge clk);
		{ue, ce, fast, ren, uen, cen} <= 6'h10;
		req <= 1'b1;
		@(posedge clk);
		req <= 1'b0;
		cclr <= 1'b1;
		@(posedge clk);
		cclr <= 1'b0;
		#1;
		chk("set beats clear", cflag, 1'b1);
		clr_all();
		// reset in mid-run drops vectors, flags and the wake window at once
		rd(6'h37);
		@(posedge clk);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		rst_b <= 1'b0;
		#1;
		chk("mid reset", {post_wake, uflag, cflag, rvec, nvec}, 0);
		@(posedge clk);
		rst_b <= 1'b1;
		#1;
		chk("release", {power_up_clear_reset, nmi, post_wake, uflag, rvec, nvec}, 0);
		test_done();
	end
endmodule // fram_bit_error_response_bench
